// ### verilog/wdrc_regs.vh
// Register map, field positions, reset values and timing constants of the watchdog reset control block.
// Contract
// RULE1: After a watchdog reset, restart from loader memory if restart_from_loader is set, else application.
// RULE2: watchdog_restart_source is written only inside an open timed-access unlock window.
// RULE3: Power-up sets the power-up flag in bit 6; hardware never clears it.
// RULE4: Watchdog time-out sets wd_timeout_flag in bit 3.
// RULE5: wd_timeout_flag stays set until software clears it.
// RULE6: With wd_reset_enable set, a watchdog reset sets wd_reset_cause_flag in bit 2.
// RULE7: wd_reset_cause_flag is readable; cleared by software write or power-fail reset.
// RULE8: wd_reset_enable in bit 1 allows watchdog resets; clear means no watchdog reset.
// RULE9: Writing 1 to wd_restart in bit 0 restarts the count; hardware then clears it.
// RULE10: External reset clears bits 7,5,3,1 of watchdog_control and keeps bits 6,4,2,0.
// RULE11: Watchdog reset sets wd_reset_cause_flag and leaves the other control bits unchanged.
// RULE12: Power-on reset clears reset-cause flag and reset enable and sets the power-up flag.
// RULE13: Every watchdog_control bit reads at any time without unlocking.
// RULE14: Power-up flag, reset enable, timeout flag and restart bit need the unlock window.
// RULE15: Other watchdog_control bits, the reset-cause flag included, are writable at any time.
// RULE16: Both upper clock_control_reg bits set select the longest interval, a 26-bit count.
// RULE17: Writing AAH then 55H to access_unlock_reg opens a three machine cycle write window.
// RULE18: wd_irq_enable in the extended interrupt enable register gates the time-out interrupt.
// RULE19: Protected writes outside an open window are ignored and keep the old value.
`ifndef WDRC_REGS_VH
`define WDRC_REGS_VH

// Special function register addresses.
`define WDRC_ADDR_CLOCK_CONTROL   8'h8e
`define WDRC_ADDR_ACCESS_UNLOCK   8'hc7
`define WDRC_ADDR_RESTART_SOURCE  8'hd7
`define WDRC_ADDR_WD_CONTROL      8'hd8
`define WDRC_ADDR_EXT_IRQ_ENABLE  8'he8

// Field positions inside watchdog_control.
`define WDRC_BIT_POWER_UP         6
`define WDRC_BIT_TIMEOUT          3
`define WDRC_BIT_RESET_CAUSE      2
`define WDRC_BIT_RESET_ENABLE     1
`define WDRC_BIT_RESTART          0

// Other field positions.
`define WDRC_BIT_LOADER           0
`define WDRC_BIT_IRQ_ENABLE       4
`define WDRC_BIT_INTERVAL_HI      7
`define WDRC_BIT_INTERVAL_LO      6

// Timed-access key bytes and window length in machine cycles.
`define WDRC_UNLOCK_KEY1          8'haa
`define WDRC_UNLOCK_KEY2          8'h55
`define WDRC_UNLOCK_MCYCLES       3

// Interval widths, counter bits, selected by the two upper clock control bits.
`define WDRC_INTERVAL_SEL0        17
`define WDRC_INTERVAL_SEL1        20
`define WDRC_INTERVAL_SEL2        23
`define WDRC_INTERVAL_SEL3        26

// Common reset and read-back constants.
`define WDRC_BYTE_ZERO            8'h00
`define WDRC_SEL_ZERO             2'h0

`endif

// ### verilog/wdrc_counter.v
// Free-running watchdog interval counter with selectable length and time-out pulse.
`timescale 1ns/100ps
`default_nettype none
`include "wdrc_regs.vh"

module wdrc_counter #(
    parameter CNT_W = `WDRC_INTERVAL_SEL3,
    parameter SEL0  = `WDRC_INTERVAL_SEL0,
    parameter SEL1  = `WDRC_INTERVAL_SEL1,
    parameter SEL2  = `WDRC_INTERVAL_SEL2,
    parameter SEL3  = `WDRC_INTERVAL_SEL3
) (
    // Clock and reset.
    input  wire             mclk_i,
    input  wire             rst_n_i,
    // Control.
    input  wire             clear_i,
    input  wire [1:0]       sel_i,
    // Status.
    output reg  [CNT_W-1:0] count_o,
    output reg              timeout_o
);

    // Terminal counts, all ones over the selected width.
    wire [CNT_W-1:0] lim0 = {CNT_W{1'b1}} >> (CNT_W - SEL0);
    wire [CNT_W-1:0] lim1 = {CNT_W{1'b1}} >> (CNT_W - SEL1);
    wire [CNT_W-1:0] lim2 = {CNT_W{1'b1}} >> (CNT_W - SEL2);
    wire [CNT_W-1:0] lim3 = {CNT_W{1'b1}} >> (CNT_W - SEL3);
    reg  [CNT_W-1:0] limit;

    // Pick the terminal count from the interval select.
    always @* begin
        case (sel_i)
            2'h0:    limit = lim0;
            2'h1:    limit = lim1;
            2'h2:    limit = lim2;
            default: limit = lim3; // Both upper bits set give the longest interval. [RULE16]
        endcase
    end

    // Compare with >= so that shrinking the interval mid-count cannot run the counter past its end.
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o   <= {CNT_W{1'b0}};
            timeout_o <= 1'b0;
        end else if (clear_i) begin
            count_o   <= {CNT_W{1'b0}}; // Restart from zero before a time-out. [RULE9]
            timeout_o <= 1'b0;
        end else if (count_o >= limit) begin
            count_o   <= {CNT_W{1'b0}};
            timeout_o <= 1'b1;
        end else begin
            count_o   <= count_o + {{(CNT_W-1){1'b0}}, 1'b1};
            timeout_o <= 1'b0;
        end
    end

endmodule // wdrc_counter
`default_nettype wire

// ### verilog/wdrc_top.v
// Watchdog control, status, timed-access unlock and reset-cause logic on the special function register port.
`timescale 1ns/100ps
`default_nettype none
`include "wdrc_regs.vh"

module wdrc_top #(
    parameter MC_CLKS = 4,                   // Clocks per machine cycle.
    parameter CNT_W   = `WDRC_INTERVAL_SEL3, // Widest interval counter.
    parameter SEL0    = `WDRC_INTERVAL_SEL0,
    parameter SEL1    = `WDRC_INTERVAL_SEL1,
    parameter SEL2    = `WDRC_INTERVAL_SEL2,
    parameter SEL3    = `WDRC_INTERVAL_SEL3
) (
    // Clock and power-on reset.
    input  wire       mclk_i,
    input  wire       rst_n_i,
    // External reset, synchronous, active high.
    input  wire       ext_rst_i,
    // Special function register port.
    input  wire [7:0] sfr_addr_i,
    input  wire       sfr_wr_i,
    input  wire [7:0] sfr_wdata_i,
    output reg  [7:0] sfr_rdata_o,
    // Watchdog outputs.
    output reg        wd_irq_o,
    output reg        wd_reset_o,
    output reg        restart_from_loader_o,
    output reg        unlock_open_o
);

    // Unlock sequencer states, one-hot.
    localparam [2:0] S_IDLE  = 3'b001;
    localparam [2:0] S_ARMED = 3'b010;
    localparam [2:0] S_OPEN  = 3'b100;

    // Window length in clocks, counted down from WIN_CLKS-1.
    localparam integer WIN_CLKS = `WDRC_UNLOCK_MCYCLES * MC_CLKS;
    localparam [7:0]   WIN_LAST = WIN_CLKS[7:0] - 8'h01;

    // Watchdog control bits.
    reg        power_up_flag;
    reg        wd_timeout_flag;
    reg        wd_reset_cause_flag;
    reg        wd_reset_enable;
    reg        wd_restart;
    // Other held bits.
    reg        restart_from_loader;
    reg        wd_irq_enable;
    reg  [1:0] interval_sel;
    // Unlock sequencer.
    reg  [2:0] ta_state;
    reg  [2:0] next_ta_state;
    reg  [7:0] win_cnt;
    reg  [7:0] next_win_cnt;

    // Counter status.
    wire [CNT_W-1:0] wd_count;
    wire             wd_timeout;

    // Decoded writes.
    wire wr_ta   = sfr_wr_i && (sfr_addr_i == `WDRC_ADDR_ACCESS_UNLOCK);
    wire wr_ctl  = sfr_wr_i && (sfr_addr_i == `WDRC_ADDR_WD_CONTROL);
    wire wr_src  = sfr_wr_i && (sfr_addr_i == `WDRC_ADDR_RESTART_SOURCE);
    wire wr_ck   = sfr_wr_i && (sfr_addr_i == `WDRC_ADDR_CLOCK_CONTROL);
    wire wr_eie  = sfr_wr_i && (sfr_addr_i == `WDRC_ADDR_EXT_IRQ_ENABLE);
    wire unlock  = (ta_state == S_OPEN);
    // Protected writes only land inside the window, otherwise they are dropped. [RULE14] [RULE19]
    wire wr_ctl_prot = wr_ctl && unlock;
    // A time-out with the reset enable set is a watchdog reset; without it none occurs. [RULE8]
    wire wd_fire = wd_timeout && wd_reset_enable;

    // Interval counter; restart bit and external reset both bring it back to zero.
    wdrc_counter #(
        .CNT_W (CNT_W),
        .SEL0  (SEL0),
        .SEL1  (SEL1),
        .SEL2  (SEL2),
        .SEL3  (SEL3)
    ) wdrc_counter_i (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .clear_i   (wd_restart | ext_rst_i), // [RULE9]
        .sel_i     (interval_sel),
        .count_o   (wd_count),
        .timeout_o (wd_timeout)
    );

    // Unlock sequencer: AAH arms, 55H as the very next write opens the window. [RULE17]
    always @* begin
        next_ta_state = ta_state;
        next_win_cnt  = win_cnt;
        case (ta_state)
            S_IDLE: begin
                if (wr_ta && sfr_wdata_i == `WDRC_UNLOCK_KEY1)
                    next_ta_state = S_ARMED;
            end
            S_ARMED: begin
                // Any write between the two keys other than a repeated AAH to the unlock register breaks the sequence. [RULE17]
                if (wr_ta && sfr_wdata_i == `WDRC_UNLOCK_KEY2) begin
                    next_ta_state = S_OPEN;
                    next_win_cnt  = WIN_LAST;
                end else if (wr_ta && sfr_wdata_i == `WDRC_UNLOCK_KEY1) begin
                    next_ta_state = S_ARMED;
                end else if (sfr_wr_i) begin
                    next_ta_state = S_IDLE;
                end
            end
            S_OPEN: begin
                // Window closes after three machine cycles whatever is written meanwhile. [RULE17]
                if (win_cnt == `WDRC_BYTE_ZERO)
                    next_ta_state = S_IDLE;
                else
                    next_win_cnt = win_cnt - 8'h01;
            end
            default: begin
                next_ta_state = S_IDLE;
                next_win_cnt  = `WDRC_BYTE_ZERO;
            end
        endcase
    end

    // Sequencer registers; an external reset also shuts any window.
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ta_state <= S_IDLE;
            win_cnt  <= `WDRC_BYTE_ZERO;
        end else if (ext_rst_i) begin
            ta_state <= S_IDLE;
            win_cnt  <= `WDRC_BYTE_ZERO;
        end else begin
            ta_state <= next_ta_state;
            win_cnt  <= next_win_cnt;
        end
    end

    // Watchdog control register. Power-on reset is the asynchronous reset. [RULE12]
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_up_flag       <= 1'b1; // [RULE3] [RULE12]
            wd_timeout_flag     <= 1'b0;
            wd_reset_cause_flag <= 1'b0; // Power-fail reset clears the cause. [RULE7] [RULE12]
            wd_reset_enable     <= 1'b0; // [RULE12]
            wd_restart          <= 1'b0;
        end else if (ext_rst_i) begin
            // Bits 6, 4, 2, 0 keep their values; 7, 5, 3, 1 go to zero. [RULE10]
            wd_timeout_flag <= 1'b0;
            wd_reset_enable <= 1'b0;
        end else begin
            // Power-up flag changes only by an unlocked write; hardware never clears it. [RULE3]
            if (wr_ctl_prot)
                power_up_flag <= sfr_wdata_i[`WDRC_BIT_POWER_UP];
            if (wr_ctl_prot)
                wd_reset_enable <= sfr_wdata_i[`WDRC_BIT_RESET_ENABLE]; // [RULE8] [RULE14]
            // Time-out sets the flag and wins over a clearing write in the same cycle. [RULE4] [RULE5]
            if (wd_timeout)
                wd_timeout_flag <= 1'b1;
            else if (wr_ctl_prot)
                wd_timeout_flag <= sfr_wdata_i[`WDRC_BIT_TIMEOUT];
            // Reset cause is set by a watchdog reset only, writable without unlock. [RULE6] [RULE11] [RULE15]
            if (wd_fire)
                wd_reset_cause_flag <= 1'b1;
            else if (wr_ctl)
                wd_reset_cause_flag <= sfr_wdata_i[`WDRC_BIT_RESET_CAUSE]; // [RULE7]
            // Restart bit lives for one clock, then hardware clears it. [RULE9]
            if (wd_restart)
                wd_restart <= 1'b0;
            else if (wr_ctl_prot)
                wd_restart <= sfr_wdata_i[`WDRC_BIT_RESTART];
        end
    end

    // Restart source, interval select and interrupt enable.
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            restart_from_loader <= 1'b0;
            interval_sel        <= `WDRC_SEL_ZERO;
            wd_irq_enable       <= 1'b0;
        end else if (ext_rst_i) begin
            restart_from_loader <= 1'b0;
            interval_sel        <= `WDRC_SEL_ZERO;
            wd_irq_enable       <= 1'b0;
        end else begin
            // Whole register is protected by the unlock window. [RULE2] [RULE19]
            if (wr_src && unlock)
                restart_from_loader <= sfr_wdata_i[`WDRC_BIT_LOADER];
            if (wr_ck)
                interval_sel <= sfr_wdata_i[`WDRC_BIT_INTERVAL_HI:`WDRC_BIT_INTERVAL_LO]; // [RULE16]
            if (wr_eie)
                wd_irq_enable <= sfr_wdata_i[`WDRC_BIT_IRQ_ENABLE];
        end
    end

    // Output flops. The boot selection is captured at the watchdog reset itself, so a later
    // change of the restart source cannot redirect a restart already under way.
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_irq_o              <= 1'b0;
            wd_reset_o            <= 1'b0;
            restart_from_loader_o <= 1'b0;
            unlock_open_o         <= 1'b0;
        end else begin
            // Interrupt request follows the sticky flag only while enabled. [RULE18]
            wd_irq_o      <= wd_timeout_flag && wd_irq_enable && !ext_rst_i;
            wd_reset_o    <= wd_fire && !ext_rst_i; // [RULE8]
            unlock_open_o <= (next_ta_state == S_OPEN) && !ext_rst_i;
            if (ext_rst_i)
                restart_from_loader_o <= 1'b0;
            else if (wd_fire)
                restart_from_loader_o <= restart_from_loader; // [RULE1]
        end
    end

    // Read mux, registered; all bits read freely, reserved bits and unmapped addresses read zero. [RULE13]
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= `WDRC_BYTE_ZERO;
        end else begin
            sfr_rdata_o <= `WDRC_BYTE_ZERO;
            case (sfr_addr_i)
                `WDRC_ADDR_WD_CONTROL: begin
                    sfr_rdata_o[`WDRC_BIT_POWER_UP]     <= power_up_flag;
                    sfr_rdata_o[`WDRC_BIT_TIMEOUT]      <= wd_timeout_flag;
                    sfr_rdata_o[`WDRC_BIT_RESET_CAUSE]  <= wd_reset_cause_flag; // [RULE7]
                    sfr_rdata_o[`WDRC_BIT_RESET_ENABLE] <= wd_reset_enable;
                    sfr_rdata_o[`WDRC_BIT_RESTART]      <= wd_restart;
                end
                `WDRC_ADDR_RESTART_SOURCE:
                    sfr_rdata_o[`WDRC_BIT_LOADER] <= restart_from_loader;
                `WDRC_ADDR_CLOCK_CONTROL:
                    sfr_rdata_o[`WDRC_BIT_INTERVAL_HI:`WDRC_BIT_INTERVAL_LO] <= interval_sel;
                `WDRC_ADDR_EXT_IRQ_ENABLE:
                    sfr_rdata_o[`WDRC_BIT_IRQ_ENABLE] <= wd_irq_enable;
                default:
                    sfr_rdata_o <= `WDRC_BYTE_ZERO;
            endcase
        end
    end

endmodule // wdrc_top
`default_nettype wire

// ### test/wdrc_checker.sv
// Concurrent checks on the ports of the watchdog reset control block.
`timescale 1ns/100ps
`default_nettype none
`include "wdrc_regs.vh"
module wdrc_checker (
    // Clock and resets.
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       ext_rst_i,
    // Register port.
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    // Watchdog outputs.
    input wire logic       wd_irq_o,
    input wire logic       wd_reset_o,
    input wire logic       restart_from_loader_o,
    input wire logic       unlock_open_o
);
    localparam logic [7:0] CTL = `WDRC_ADDR_WD_CONTROL;
    // Second key byte and control writes, decoded once for the properties.
    wire key2   = sfr_wr_i && sfr_addr_i == `WDRC_ADDR_ACCESS_UNLOCK && sfr_wdata_i == `WDRC_UNLOCK_KEY2;
    wire ctl_wr = sfr_wr_i && sfr_addr_i == CTL;
    // One domain, so the clock and the power reset are given once.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // The window opens only behind the second key byte.
    property p_open_rise;
        $rose(unlock_open_o) |-> $past(key2);
    endproperty
    a_open_rise: assert property (p_open_rise) else $error("window opened without key");
    // Three machine cycles of four clocks each.
    property p_open_len;
        $rose(unlock_open_o) |-> unlock_open_o [*8] ##1 unlock_open_o [*4] ##1 !unlock_open_o;
    endproperty
    a_open_len: assert property (p_open_len) else $error("window length wrong");
    // An external reset drops every watchdog output.
    property p_ext_clear;
        ext_rst_i |=> !(wd_irq_o || wd_reset_o || unlock_open_o || restart_from_loader_o);
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("outputs kept over external reset");
    // Reserved control bits always read as zero, unlocked or not.
    property p_reserved;
        $past(sfr_addr_i) == CTL |-> (sfr_rdata_o & 8'hb0) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved control bits set");
    // Power-up and cause flags are never cleared by hardware alone.
    property p_sticky;
        $past(sfr_addr_i) == CTL && sfr_addr_i == CTL && !$past(ctl_wr)
            |=> (($past(sfr_rdata_o) & 8'h44) & ~sfr_rdata_o) == 8'h00;
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky flag cleared");
    // The time-out flag waits for software or an external reset.
    property p_timeout_kept;
        sfr_rdata_o[3] && $past(sfr_addr_i) == CTL && sfr_addr_i == CTL && !$past(ctl_wr) && !$past(ext_rst_i)
            |-> ##1 sfr_rdata_o[3];
    endproperty
    a_timeout_kept: assert property (p_timeout_kept) else $error("timeout flag dropped");
    // A watchdog reset leaves the cause flag set.
    property p_cause;
        wd_reset_o && sfr_addr_i == CTL |=> sfr_rdata_o[2];
    endproperty
    a_cause: assert property (p_cause) else $error("cause flag missing");
    // A reset request is a one-clock pulse followed by at least eight quiet clocks.
    property p_pulse;
        wd_reset_o |=> !wd_reset_o [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");
endmodule // wdrc_checker

bind wdrc_top wdrc_checker wdrc_checker_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ext_rst_i(ext_rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .wd_irq_o(wd_irq_o),
    .wd_reset_o(wd_reset_o), .restart_from_loader_o(restart_from_loader_o), .unlock_open_o(unlock_open_o)
);
`default_nettype wire

// ### test/watchdog_reset_control_bench.sv
// Self-checking bench for the watchdog reset control block.
`timescale 1ns/100ps
`default_nettype none
`include "wdrc_regs.vh"
module watchdog_reset_control_bench;
    localparam logic [7:0] CTL = `WDRC_ADDR_WD_CONTROL;
    localparam logic [7:0] SRC = `WDRC_ADDR_RESTART_SOURCE;
    // Design ports and bench state.
    logic       mclk_i      = 1'b0;
    logic       rst_n_i     = 1'b0;
    logic       ext_rst_i   = 1'b0;
    logic [7:0] sfr_addr_i  = 8'h00;
    logic       sfr_wr_i    = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    wire  [7:0] sfr_rdata_o;
    wire        wd_irq_o;
    wire        wd_reset_o;
    wire        restart_from_loader_o;
    wire        unlock_open_o;
    int         errors   = 0;
    int         compares = 0;
    int         cycles   = 0;
    int         n;
    logic [7:0] rv;
    // Free-running 100 MHz clock.
    always #5 mclk_i = ~mclk_i;
    // Short intervals: selector 0 times out every 16 clocks, selector 3 every 128.
    wdrc_top #(.CNT_W(7), .SEL0(4), .SEL1(5), .SEL2(6), .SEL3(7)) wdrc_top_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ext_rst_i(ext_rst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .wd_irq_o(wd_irq_o),
        .wd_reset_o(wd_reset_o), .restart_from_loader_o(restart_from_loader_o), .unlock_open_o(unlock_open_o)
    );
    // Verdict and end of run.
    task automatic summarize();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Comparison with four-state equality so an unknown never matches.
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One register write; the strobe drops for a cycle between writes.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        sfr_wr_i    <= 1'b1;
        sfr_addr_i  <= a;
        sfr_wdata_i <= d;
        @(posedge mclk_i);
        sfr_wr_i <= 1'b0;
    endtask
    // Read data trails the sampled address by one edge.
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        sfr_addr_i <= a;
        repeat (2) @(posedge mclk_i);
        #1 rv = sfr_rdata_o;
    endtask
    task automatic unlock();
        wr(`WDRC_ADDR_ACCESS_UNLOCK, `WDRC_UNLOCK_KEY1);
        wr(`WDRC_ADDR_ACCESS_UNLOCK, `WDRC_UNLOCK_KEY2);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    // Count clocks up to the next reset request, bounded.
    task automatic wait_pulse();
        for (n = 1; n < 300; n++) begin
            tick(1);
            if (wd_reset_o === 1'b1) break;
        end
    endtask
    // Reset values, read before the first time-out lands.
    task automatic t_reset();
        rd(CTL);
        chk("control", 8'h40, rv);
        rd(SRC);
        chk("restart source", 8'h00, rv);
        rd(8'h10);
        chk("unmapped", 8'h00, rv);
    endtask
    // Time-out with resets disabled, then locked and free writes.
    task automatic t_timeout();
        repeat (20) begin
            tick(1);
            chk("wd_reset_o", 8'h00, {7'h00, wd_reset_o});
        end
        rd(CTL);
        chk("control", 8'h48, rv);
        wr(CTL, 8'h40);
        rd(CTL);
        chk("locked clear", 8'h48, rv);
        wr(CTL, 8'h44);
        rd(CTL);
        chk("free cause write", 8'h4c, rv);
        wr(CTL, 8'h48);
        rd(CTL);
        chk("cause cleared", 8'h48, rv);
    endtask
    task automatic t_irq();
        wr(`WDRC_ADDR_EXT_IRQ_ENABLE, 8'h10);
        tick(3);
        chk("wd_irq_o", 8'h01, {7'h00, wd_irq_o});
        wr(`WDRC_ADDR_EXT_IRQ_ENABLE, 8'h00);
        tick(3);
        chk("wd_irq_o", 8'h00, {7'h00, wd_irq_o});
    endtask
    // Unlocked restart and flag clear, then a write after the window closes.
    task automatic t_restart();
        unlock();
        wr(CTL, 8'h41);
        rd(CTL);
        chk("restart", 8'h40, rv);
        rd(CTL);
        chk("count restarted", 8'h40, rv);
        chk("unlock_open_o", 8'h01, {7'h00, unlock_open_o});
        tick(8);
        chk("unlock_open_o", 8'h00, {7'h00, unlock_open_o});
        wr(CTL, 8'h42);
        rd(CTL);
        chk("late enable", 8'h00, rv & 8'h02);
    endtask
    // Watchdog resets with both restart sources.
    task automatic t_cause();
        unlock();
        wr(CTL, 8'h42);
        wait_pulse();
        chk("loader", 8'h00, {7'h00, restart_from_loader_o});
        rd(CTL);
        chk("after reset", 8'h4e, rv);
        wr(SRC, 8'h01);
        rd(SRC);
        chk("locked source", 8'h00, rv);
        unlock();
        wr(SRC, 8'h01);
        rd(SRC);
        chk("source", 8'h01, rv);
        wait_pulse();
        chk("loader", 8'h01, {7'h00, restart_from_loader_o});
    endtask
    task automatic t_ext();
        @(posedge mclk_i);
        ext_rst_i <= 1'b1;
        @(posedge mclk_i);
        ext_rst_i <= 1'b0;
        rd(CTL);
        chk("external reset", 8'h44, rv);
        rd(SRC);
        chk("source", 8'h00, rv);
        chk("loader", 8'h00, {7'h00, restart_from_loader_o});
    endtask
    // Intervals of selectors 1 to 3, each measured between two reset requests; the bench widths are 4 plus k.
    task automatic t_interval();
        logic [1:0] s;
        unlock();
        wr(CTL, 8'h43);
        for (int k = 1; k < 4; k++) begin
            s = k[1:0];
            wr(`WDRC_ADDR_CLOCK_CONTROL, {s, 6'h00});
            wait_pulse();
            wait_pulse();
            chk("interval", 8'h10 << k, n[7:0]);
        end
    endtask
    task automatic t_power();
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(CTL);
        chk("power reset", 8'h40, rv);
        chk("loader", 8'h00, {7'h00, restart_from_loader_o});
    endtask
    // Hang guard, well above the few hundred clocks of the sequence.
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end
    // Main sequence.
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_timeout();
        t_irq();
        t_restart();
        t_cause();
        t_ext();
        t_interval();
        t_power();
        summarize();
    end
endmodule // watchdog_reset_control_bench
`default_nettype wire
